// [bench/cst_tb.sv]
// self-checking bench for the clock switch and reset timers
`timescale 1ns/100ps
`include "cst_map.vh"
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por = 1'b0, ext_n = 1'b1, slow = 1'b0, xtal = 1'b0, sosc = 1'b0;
  logic srun = 1'b0, prdy = 1'b1, wake = 1'b0, pdis = 1'b0, idl = 1'b0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, pmx = 1'b0;
  logic [3:0] mode = 4'h2, adr = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  wire [31:0] dat_o;
  wire ack, hold, usec, gate, pen;
  int n_mismatch = 0, checked = 0, cyc_n = 0, n, e;

  cst_top #(.PLL_CYC(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por), .ext_rst_n_i(ext_n),
    .slow_clk_i(slow), .xtal_clk_i(xtal), .sosc_clk_i(sosc), .sosc_running_i(srun),
    .pri_ready_i(prdy), .wake_i(wake), .pm_exit_i(pmx), .osc_mode_i(mode),
    .put_dis_cfg_i(pdis), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .dev_hold_o(hold),
    .use_sec_clk_o(usec), .clk_gate_o(gate), .pri_osc_en_o(pen));

  // ------------------------------------------------------------
  // clocks and hang guard
  // ------------------------------------------------------------
  always #20 clk_i = ~clk_i;

  // slow and crystal rise at different rates so swapped counters show up
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    slow <= ~slow;
    sosc <= ~sosc;
    if (cyc_n % 3 == 0)
      xtal <= ~xtal;
    if (cyc_n == 60000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task conclude;
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, x, s);
    end
  endtask

  // ack and read data are sampled at the rising edge itself; only the hang guard ends a wait
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // cycles from end of power-on pulse to release
  function int tmo(input logic [3:0] m, input logic d);
    tmo = d ? 0 : 4096;
    if (m == `CST_MODE_XLOW || m == `CST_MODE_XSTD || m == `CST_MODE_XFAST ||
      m == `CST_MODE_XPLL)
      tmo += 6144;
    if (m == `CST_MODE_XPLL)
      tmo += 20;
  endfunction

  task pw(input logic [3:0] m, input logic d, input logic pl);
    @(posedge clk_i);
    mode <= m;
    pdis <= d;
    por <= 1'b1;
    ext_n <= ~pl;
    repeat (4) @(posedge clk_i);
    por <= 1'b0;
    mode <= 4'h5;
    pdis <= ~d;
    e = tmo(m, d);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (hold !== 1'b0 && n < e + 40);
    if (pl)
    begin
      chk("hold_pin", hold, 1);
      @(posedge clk_i);
      ext_n <= 1'b1;
      repeat (5) @(negedge clk_i);
      chk("hold_rel", hold, 0);
    end
    else
      chk("timeout", n >= e - 6 && n <= e + 10, 1);
    wb(0, `CST_ADR_CFG, 0);
    chk("cfg", rd, {28'h0, m});
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(39));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `CST_ADR_STAT, 0);
    chk("stat_rst", rd[3:2], 2'h3);
    pw(`CST_MODE_XFAST, 0, 0);
    pw(`CST_MODE_XPLL, 1, 0);
    pw(`CST_MODE_XSTD, 1, 1);
    // exit from a power-managed mode reruns the crystal start-up count
    @(posedge clk_i);
    pmx <= 1'b1;
    @(posedge clk_i);
    pmx <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk("pmx_hold", hold, 1);
    e = tmo(`CST_MODE_XSTD, 1'b1);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (hold !== 1'b0 && n < e + 40);
    chk("pmx_rel", n >= e - 10 && n <= e + 10, 1);
    pw(`CST_MODE_XLOW, 1, 0);
    pw(`CST_MODE_RCOSC, 1, 0);
    pw(`CST_MODE_RCIO, 0, 0);
    idl = $urandom_range(1, 0);
    wb(1, `CST_ADR_CTRL, {28'h0, idl, 3'h1});
    repeat (40) @(negedge clk_i);
    chk("sec_blocked", usec, 0);
    chk("sec_blocked_gate", gate, 0);
    wb(1, `CST_ADR_CTRL, {28'h0, idl, 3'h5});
    n = 0;
    while (gate !== 1'b1 && n < 50)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("gate", gate, 1);
    chk("no_sec_yet", usec, 0);
    @(posedge clk_i);
    srun <= 1'b1;
    n = 0;
    while (usec !== 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("sec_on", usec, 1);
    chk("pri_off", pen, 0);
    chk("ungated", gate, 0);
    wb(0, `CST_ADR_STAT, 0);
    chk("stat_sec", rd[3:0], 4'h1);
    @(posedge clk_i);
    prdy <= 1'b0;
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    repeat ($urandom_range(60, 20)) @(negedge clk_i);
    chk("pri_start", pen, 1);
    chk("still_sec", usec, 1);
    @(posedge clk_i);
    prdy <= 1'b1;
    n = 0;
    while (usec !== 1'b0 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("back_pri", usec, 0);
    wb(0, `CST_ADR_STAT, 0);
    chk("stat_pri", rd[3:0], 4'ha);
    chk("stay_pri", usec, 0);
    wb(1, 4'hc, 32'hffffffff);
    wb(0, 4'hc, 0);
    chk("unmapped", rd, 0);
    wb(0, `CST_ADR_CTRL, 0);
    chk("ctrl_kept", rd[3:0], {idl, 3'h5});
    wb(1, `CST_ADR_CTRL, {28'h0, idl, 3'h5});
    repeat (60) @(negedge clk_i);
    chk("sec_again", usec, 1);
    wb(1, `CST_ADR_CTRL, {28'h0, idl, 3'h4});
    repeat (60) @(negedge clk_i);
    chk("pri_by_sel", usec, 0);
    chk("pri_by_sel_pen", pen, 1);
    conclude();
  end
endmodule // testbench

// [bench/cst_top_sva.sv]
// port assertions for the clock switch and reset timer block
`timescale 1ns/100ps
module cst_chk
(
  input wire clk_i, // system clock
  input wire rst_i, // synchronous reset
  input wire por_i, // power-on pulse
  input wire ext_rst_n_i, // external reset pin
  input wire sosc_running_i, // secondary osc started
  input wire wb_cyc_i, // bus cycle
  input wire wb_stb_i, // bus strobe
  input wire wb_ack_o, // bus acknowledge
  input wire dev_hold_o, // device held in reset
  input wire use_sec_clk_o, // core on secondary clock
  input wire pri_osc_en_o // primary osc on
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  chk_hold_por: assert property (por_i |=> dev_hold_o)
    else $error("released during power-on pulse");
  chk_hold_pin: assert property (!ext_rst_n_i |-> ##[1:3] dev_hold_o)
    else $error("released while pin low");
  chk_release_cause: assert property ($fell(dev_hold_o) |-> $past(ext_rst_n_i) && !$past(por_i))
    else $error("release without cause");
  chk_sec_pri_off: assert property ($rose(use_sec_clk_o) |-> !pri_osc_en_o)
    else $error("primary osc left on in secondary run");
  chk_back_pri_on: assert property ($fell(use_sec_clk_o) |-> pri_osc_en_o)
    else $error("switched back with primary off");
  chk_sec_after_run: assert property ($rose(use_sec_clk_o) |-> $past(sosc_running_i))
    else $error("secondary used before running");
  chk_hold_reset: assert property ($fell(rst_i) |-> dev_hold_o)
    else $error("not held after reset");
endmodule // cst_chk

bind cst_top cst_chk u_chk (.clk_i, .rst_i, .por_i, .ext_rst_n_i, .sosc_running_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .dev_hold_o, .use_sec_clk_o, .pri_osc_en_o);

// [logic/cst_count.v]
// up counter with clear, advance strobe and terminal flag
`timescale 1ns/100ps
`include "cst_map.vh"
module cst_count
#(
  parameter W = 11
)
(
  input wire clk_i, // system clock
  input wire clr_i, // clear to zero
  input wire adv_i, // count one step
  input wire [W-1:0] last_i, // terminal value
  output wire done_o // step taken while at terminal value
);
  reg [W-1:0] cnt_r;
  always @(posedge clk_i)
  begin
    if (clr_i)
      cnt_r <= {W{1'b0}};
    else if (adv_i && cnt_r != last_i)
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
  end
  // the step after the terminal value ends the run, so a W-bit count spans 2**W steps
  assign done_o = adv_i & (cnt_r == last_i);
endmodule // cst_count

// [logic/cst_edge.v]
// edge detector for a slow clock that is sampled on the system clock
`timescale 1ns/100ps
`include "cst_map.vh"
module cst_edge
(
  input wire clk_i, // system clock
  input wire rst_i, // synchronous reset
  input wire lvl_i, // sampled clock level
  output wire rise_o // one-cycle pulse on a rising edge
);
  reg prev_r;
  always @(posedge clk_i)
  begin
    // seeded from the pin so a high level at reset is not taken for an edge
    if (rst_i)
      prev_r <= lvl_i;
    else
      prev_r <= lvl_i;
  end
  assign rise_o = lvl_i & ~prev_r;
endmodule // cst_edge

// [logic/cst_map.vh]
// register offsets, field positions and timing constants of the clock switch and reset timers
`ifndef CST_MAP_VH
`define CST_MAP_VH
`define CST_ADR_CTRL 4'h0
`define CST_ADR_STAT 4'h4
`define CST_ADR_CFG 4'h8
`define CST_SCS_LO 0
`define CST_SCS_HI 1
`define CST_BIT_SOSCEN 2
`define CST_BIT_IDLE 3
`define CST_SCS_SEC 2'h1
`define CST_BIT_SRUN 0
`define CST_BIT_PACT 1
`define CST_BIT_HOLD 2
`define CST_BIT_PEN 3
`define CST_MODE_XLOW 4'h0
`define CST_MODE_XSTD 4'h1
`define CST_MODE_XFAST 4'h2
`define CST_MODE_XPLL 4'h6
`define CST_MODE_RCOSC 4'h3
`define CST_MODE_RCIO 4'h7
`define CST_PUT_BITS 11
`define CST_PUT_LAST 11'h7ff
`define CST_XSU_BITS 10
`define CST_XSU_LAST 10'h3ff
`define CST_PLL_MS 2
`define CST_CLK_KHZ 25000
`define CST_OLD_CYC 2'h2
`define CST_NEW_CYC 3'h3
`define CST_WB_ZERO 32'h00000000
`endif

// [logic/cst_top.v]
// clock switch between primary and secondary oscillator and start-up reset timers
//
// How it works
// [R1] clock select 01 requests secondary run
// [R2] secondary run: secondary clock, primary stopped, flags
// [R3] secondary enable clear blocks secondary run
// [R4] clocks withheld until secondary oscillator runs
// [R5] return keeps secondary clock until primary ready
// [R6] return done: clear secondary flag, set primary
// [R7] return leaves select bits, secondary keeps running
// [R8] power-up timer: 11 bits on slow clock
// [R9] reset held while power-up timer counts
// [R10] power-up timer only when disable bit zero
// [R11] then 1024 crystal cycles before release
// [R12] start-up count only in crystal modes
// [R13] pll mode adds 2 ms lock delay
// [R14] sequence starts when power-on pulse ends
// [R15] rc mode without power-up timer: no wait
// [R16] timers ignore reset pin; release immediate
// [R17] power-up delay applies in every mode
// [R18] primary active flag means primary clock
// [R19] switch: two old plus three new cycles
// [R20] mode and timer config sampled at power-on
`timescale 1ns/100ps
`include "cst_map.vh"
module cst_top
#(
  parameter PLL_CYC = `CST_PLL_MS * `CST_CLK_KHZ // lock delay in system cycles
)
(
  input wire clk_i, // system clock, 25 MHz
  input wire rst_i, // synchronous reset, active high
  input wire por_i, // power-on reset pulse, active high
  input wire ext_rst_n_i, // external reset pin, active low
  input wire slow_clk_i, // internal slow clock level
  input wire xtal_clk_i, // crystal input pin level
  input wire sosc_clk_i, // secondary oscillator level
  input wire sosc_running_i, // secondary oscillator has started
  input wire pri_ready_i, // primary clock is ready
  input wire wake_i, // wake-up request back to primary run
  input wire pm_exit_i, // exit from a power-managed mode
  input wire [3:0] osc_mode_i, // oscillator mode configuration
  input wire put_dis_cfg_i, // power-up timer disable configuration
  input wire [3:0] wb_adr_i, // wishbone address
  input wire [31:0] wb_dat_i, // wishbone write data
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire wb_we_i, // wishbone write enable
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  output reg [31:0] wb_dat_o, // wishbone read data
  output wire wb_ack_o, // wishbone acknowledge
  output reg dev_hold_o, // device held in reset
  output reg use_sec_clk_o, // core clocked from secondary oscillator
  output reg clk_gate_o, // core clocks withheld
  output reg pri_osc_en_o // primary oscillator running
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [5:0] S_POR = 6'h01;
  localparam [5:0] S_PUT = 6'h02;
  localparam [5:0] S_XSU = 6'h04;
  localparam [5:0] S_PLL = 6'h08;
  localparam [5:0] S_WAIT = 6'h10;
  localparam [5:0] S_RUN = 6'h20;
  localparam [4:0] C_PRI = 5'h01;
  localparam [4:0] C_WSEC = 5'h02;
  localparam [4:0] C_SW = 5'h04;
  localparam [4:0] C_SEC = 5'h08;
  localparam [4:0] C_RET = 5'h10;
  localparam [31:0] PLL_C = PLL_CYC;

  reg [5:0] st_r;
  reg [5:0] st_nxt;
  reg [4:0] cs_r;
  reg [4:0] cs_nxt;
  reg [3:0] mode_r;
  reg put_dis_r;
  reg [1:0] scs_r;
  reg sosc_en_r;
  reg sec_req_r;
  reg idle_sel_r;
  reg secondary_run_mode_r;
  reg pact_r;
  reg pexit_r;
  reg [1:0] old_cnt_r;
  reg [2:0] new_cnt_r;
  reg [31:0] pll_cnt_r;
  reg ack_r;
  wire slow_rise;
  wire xtal_rise;
  wire sosc_rise;
  wire old_rise;
  wire put_done;
  wire xsu_done;
  wire xtal_mode;
  wire rc_mode;
  wire pll_mode;
  wire wb_req;
  wire wb_wr;
  wire pll_done;

  // ---------------------------------------------------------------
  // edge detectors and counters
  // ---------------------------------------------------------------
  cst_edge u_slow (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(slow_clk_i), .rise_o(slow_rise));
  cst_edge u_xtal (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(xtal_clk_i), .rise_o(xtal_rise));
  cst_edge u_sosc (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(sosc_clk_i), .rise_o(sosc_rise));

  // power-up timer: 2048 slow-clock periods
  cst_count #(.W(`CST_PUT_BITS)) u_put
  (
    .clk_i(clk_i),
    .clr_i(st_r != S_PUT),
    .adv_i(slow_rise), // [R8]
    .last_i(`CST_PUT_LAST),
    .done_o(put_done)
  );

  // start-up count: 1024 crystal edges
  cst_count #(.W(`CST_XSU_BITS)) u_xsu
  (
    .clk_i(clk_i),
    .clr_i(st_r != S_XSU),
    .adv_i(xtal_rise), // [R11]
    .last_i(`CST_XSU_LAST),
    .done_o(xsu_done)
  );

  assign old_rise = (cs_r == C_SW) ? xtal_rise : sosc_rise;
  assign xtal_mode = (mode_r == `CST_MODE_XLOW) | (mode_r == `CST_MODE_XSTD) |
    (mode_r == `CST_MODE_XFAST) | (mode_r == `CST_MODE_XPLL); // [R12]
  assign rc_mode = (mode_r == `CST_MODE_RCOSC) | (mode_r == `CST_MODE_RCIO);
  assign pll_mode = (mode_r == `CST_MODE_XPLL);
  assign pll_done = (pll_cnt_r >= PLL_C - 32'h00000001);

  // ---------------------------------------------------------------
  // configuration capture
  // ---------------------------------------------------------------
  // sampled while the power-on pulse is high, so late strap changes cannot bend the sequence
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= `CST_MODE_XFAST;
      put_dis_r <= 1'b0;
    end
    else if (por_i)
    begin
      mode_r <= osc_mode_i; // [R20]
      put_dis_r <= put_dis_cfg_i; // [R20]
    end
  end

  // ---------------------------------------------------------------
  // time-out sequence
  // ---------------------------------------------------------------
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      S_POR:
        if (!por_i) // [R14]
        begin
          if (!put_dis_r)
            st_nxt = S_PUT; // [R10] [R17]
          else if (rc_mode)
            st_nxt = S_WAIT; // [R15]
          else if (xtal_mode)
            st_nxt = S_XSU;
          else
            st_nxt = S_WAIT;
        end
      S_PUT:
        if (put_done)
          st_nxt = xtal_mode ? S_XSU : S_WAIT; // [R9]
      S_XSU:
        if (xsu_done)
          st_nxt = pll_mode ? S_PLL : S_WAIT; // [R11]
      S_PLL:
        if (pll_done)
          st_nxt = S_WAIT; // [R13]
      S_WAIT:
        if (ext_rst_n_i)
          st_nxt = S_RUN; // [R16]
      S_RUN:
        if (!ext_rst_n_i)
          st_nxt = S_WAIT;
        else if (pexit_r && xtal_mode)
          st_nxt = S_XSU; // [R12]
      default:
        st_nxt = S_POR;
    endcase
    if (por_i)
      st_nxt = S_POR;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= S_POR;
      pll_cnt_r <= `CST_WB_ZERO;
      dev_hold_o <= 1'b1;
      pexit_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      pexit_r <= pm_exit_i & (st_r == S_RUN);
      dev_hold_o <= (st_nxt != S_RUN); // [R9]
      if (st_r == S_PLL)
        pll_cnt_r <= pll_cnt_r + 32'h00000001;
      else
        pll_cnt_r <= `CST_WB_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // clock switch
  // ---------------------------------------------------------------
  always @*
  begin
    cs_nxt = cs_r;
    case (cs_r)
      C_PRI:
        if (sec_req_r && scs_r == `CST_SCS_SEC && sosc_en_r) // [R1] [R3]
          cs_nxt = sosc_running_i ? C_SW : C_WSEC; // [R4]
      C_WSEC:
        if (!sosc_en_r || scs_r != `CST_SCS_SEC)
          cs_nxt = C_PRI;
        else if (sosc_running_i)
          cs_nxt = C_SW;
      C_SW:
        if (new_cnt_r == `CST_NEW_CYC)
          cs_nxt = C_SEC; // [R19]
      C_SEC:
        if (wake_i || scs_r != `CST_SCS_SEC)
          cs_nxt = C_RET; // [R5]
      C_RET:
        if (new_cnt_r == `CST_NEW_CYC)
          cs_nxt = C_PRI; // [R6]
      default:
        cs_nxt = C_PRI;
    endcase
  end

  // the switch counts two edges of the old source, then three of the new one
  always @(posedge clk_i)
  begin
    if (rst_i || st_r != S_RUN)
    begin
      cs_r <= C_PRI;
      old_cnt_r <= 2'h0;
      new_cnt_r <= 3'h0;
      secondary_run_mode_r <= 1'b0;
      pact_r <= 1'b1;
      use_sec_clk_o <= 1'b0;
      clk_gate_o <= 1'b0;
      pri_osc_en_o <= 1'b1;
    end
    else
    begin
      cs_r <= cs_nxt;
      if (cs_nxt != cs_r)
      begin
        old_cnt_r <= 2'h0;
        new_cnt_r <= 3'h0;
      end
      else if ((cs_r == C_SW || cs_r == C_RET) && !(cs_r == C_RET && !pri_ready_i))
      begin
        if (old_cnt_r != `CST_OLD_CYC)
        begin
          if (old_rise)
            old_cnt_r <= old_cnt_r + 2'h1; // [R19]
        end
        else if ((cs_r == C_SW ? sosc_rise : xtal_rise) && new_cnt_r != `CST_NEW_CYC)
          new_cnt_r <= new_cnt_r + 3'h1; // [R19]
      end
      clk_gate_o <= (cs_nxt == C_WSEC); // [R4]
      if (cs_nxt == C_SEC)
      begin
        use_sec_clk_o <= 1'b1; // [R2]
        pri_osc_en_o <= 1'b0; // [R2]
        secondary_run_mode_r <= 1'b1; // [R2]
        pact_r <= 1'b0; // [R2] [R18]
      end
      else if (cs_nxt == C_RET)
      begin
        pri_osc_en_o <= 1'b1; // [R5]
        use_sec_clk_o <= 1'b1; // [R5]
      end
      else if (cs_nxt == C_PRI)
      begin
        use_sec_clk_o <= 1'b0;
        secondary_run_mode_r <= 1'b0; // [R6]
        pact_r <= 1'b1; // [R6] [R18]
      end
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr = wb_req & wb_we_i;
  assign wb_ack_o = ack_r;

  // the wake-up return writes nothing here, so select bits survive it
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      scs_r <= 2'h0;
      sosc_en_r <= 1'b0;
      idle_sel_r <= 1'b0;
      sec_req_r <= 1'b0;
      wb_dat_o <= `CST_WB_ZERO;
    end
    else
    begin
      ack_r <= wb_req;
      // request consumed once switching starts, so a wake-up return is not undone
      if (cs_r == C_SW || cs_r == C_SEC || cs_r == C_RET)
        sec_req_r <= 1'b0;
      if (wb_wr && wb_adr_i == `CST_ADR_CTRL && wb_sel_i[0])
      begin
        scs_r <= wb_dat_i[`CST_SCS_HI:`CST_SCS_LO]; // [R1] [R7]
        sosc_en_r <= wb_dat_i[`CST_BIT_SOSCEN]; // [R7]
        idle_sel_r <= wb_dat_i[`CST_BIT_IDLE]; // [R7]
        sec_req_r <= (wb_dat_i[`CST_SCS_HI:`CST_SCS_LO] == `CST_SCS_SEC) &
          wb_dat_i[`CST_BIT_SOSCEN]; // [R1] [R3]
      end
      wb_dat_o <= `CST_WB_ZERO;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `CST_ADR_CTRL:
          begin
            wb_dat_o[`CST_SCS_HI:`CST_SCS_LO] <= scs_r;
            wb_dat_o[`CST_BIT_SOSCEN] <= sosc_en_r;
            wb_dat_o[`CST_BIT_IDLE] <= idle_sel_r;
          end
          `CST_ADR_STAT:
          begin
            wb_dat_o[`CST_BIT_SRUN] <= secondary_run_mode_r;
            wb_dat_o[`CST_BIT_PACT] <= pact_r;
            wb_dat_o[`CST_BIT_HOLD] <= dev_hold_o;
            wb_dat_o[`CST_BIT_PEN] <= pri_osc_en_o;
          end
          `CST_ADR_CFG:
            wb_dat_o[3:0] <= mode_r;
          default:
            wb_dat_o <= `CST_WB_ZERO;
        endcase
      end
    end
  end
endmodule // cst_top
